// >>> spa_regs.svh
/*
 * constants of the phase-aligned differential channel: mode limits,
 * phase aligner sizes and synchronizer buffer sizes.
 * assumes inclusion by bare name from every file that uses its constants.
 */
`ifndef SPA_REGS_SVH
`define SPA_REGS_SVH

// -----------------------------------------------------------------
// clock multiplication factor
// -----------------------------------------------------------------
`define SPA_MULT_W 6
`define SPA_MULT_MIN 6'h01
`define SPA_MULT_MAX 6'h20
`define SPA_MULT_DEF 6'h01

// -----------------------------------------------------------------
// serialisation factor
// -----------------------------------------------------------------
`define SPA_SER_W 4
`define SPA_SER_PASS 4'h1
`define SPA_SER_DDR 4'h2
`define SPA_SER_MIN 4'h4
`define SPA_SER_MAX 4'ha
`define SPA_SER_DEF 4'ha
`define SPA_WORD_W 10

// -----------------------------------------------------------------
// phase aligner
// -----------------------------------------------------------------
`define SPA_PHASES 8
`define SPA_PHASE_HALF 3'h4
`define SPA_WIN_LAST 5'h1f

// -----------------------------------------------------------------
// synchronizer buffer: {pair flag, second bit, first bit}
// -----------------------------------------------------------------
`define SPA_FIFO_W 3
`define SPA_FIFO_DEPTH 16
`define SPA_ENT_PAIR 2
`define SPA_ENT_B1 1
`define SPA_ENT_B0 0

`endif

// >>> spa_pkg.sv
/*
 * types shared by the phase-aligned differential channel.
 * assumes spa_regs.svh for widths.
 */
`include "spa_regs.svh"

package spa_pkg;

    // -------------------------------------------------------------
    // phase aligner states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        SPA_ST_SEARCH = 3'h1,
        SPA_ST_CHECK = 3'h2,
        SPA_ST_LOCK = 3'h4
    } spa_align_t;

    typedef logic [`SPA_WORD_W-1:0] spa_word_t;

endpackage : spa_pkg

// >>> spa_sync.sv
/*
 * three-stage level synchronizer; the output follows once the second
 * and third stages agree.
 * assumes the input is a level, or a gray code changing one bit at a time.
 */
`timescale 1ns/1ps

module spa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // -------------------------------------------------------------
    // stages
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (s2_q == s3_q) begin
            q <= s3_q;
        end
    end

endmodule : spa_sync

// >>> spa_fifo.sv
/*
 * dual-clock buffer with gray-coded pointers.
 * assumes the write side and read side run on unrelated clocks.
 */
`timescale 1ns/1ps

module spa_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_q;
    logic [AW:0] rbin_q;
    logic [AW:0] wgray;
    logic [AW:0] rgray;
    logic [AW:0] wgray_r;
    logic [AW:0] rgray_w;
    logic [AW:0] wbin_nx;
    logic [AW:0] rbin_nx;

    assign wgray = wbin_q ^ (wbin_q >> 1);
    assign rgray = rbin_q ^ (rbin_q >> 1);
    assign wbin_nx = wbin_q + {{AW{1'b0}}, 1'b1};
    assign rbin_nx = rbin_q + {{AW{1'b0}}, 1'b1};

    // -------------------------------------------------------------
    // pointer crossings
    // -------------------------------------------------------------
    spa_sync #(.WIDTH(AW + 1)) u_rptr (
        .clk(wr_clk),
        .rst_n(wr_rst_n),
        .d(rgray),
        .q(rgray_w)
    );

    spa_sync #(.WIDTH(AW + 1)) u_wptr (
        .clk(rd_clk),
        .rst_n(rd_rst_n),
        .d(wgray),
        .q(wgray_r)
    );

    // -------------------------------------------------------------
    // write side
    // -------------------------------------------------------------
    assign wr_ready = wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};

    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin_q <= '0;
        end else if (wr_valid && wr_ready) begin
            wbin_q <= wbin_nx;
        end
    end

    // -------------------------------------------------------------
    // read side
    // -------------------------------------------------------------
    assign rd_valid = rgray != wgray_r;
    assign rd_data = mem[rbin_q[AW-1:0]];

    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin_q <= '0;
        end else if (rd_valid && rd_ready) begin
            rbin_q <= rbin_nx;
        end
    end

endmodule : spa_fifo

// >>> spa_channel.sv
/*
 * one differential channel: transmit serialiser with forwarded clock and
 * fabric strobe, receive phase aligner, synchronizer, realigner and
 * deserialiser.
 * assumes CORE_CLK is the high-speed bit clock and LINK_CLK the phase
 * clock of the link; the io_element delivers eight phase samples per bit
 * and the two halves of a double-rate capture on LINK_CLK.
 */
`timescale 1ns/1ps
`include "spa_regs.svh"

// Operation
// - clock multiplication factor accepted from 1 to 32
// - word width per channel set by serialisation factor 4 to 10
// - every factor 4 to 10 works with the phase aligner in use
// - factor 1 passes the single-bit stream straight through
// - factor 2 uses double-rate io_element registers instead of shifting
// - receive path: phase select, synchronizer, realigner, deserialiser
// - aligner bypass keeps reception working, switchable at run time
// - three clocks: bit clock, forwarded fast clock, fabric strobe
// - pick the one of eight phases nearest the data eye centre
// - lock onto the chosen phase so skew does not disturb capture
// - write synchronizer on aligned clock, read on high-speed clock
// - a fabric slip request shifts the word boundary by one bit; one made while another is still pending adds no shift unless made as that one is used
module spa_channel
    import spa_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CORE_CE,
    input wire logic LINK_CLK,
    input wire logic [`SPA_MULT_W-1:0] MULT_FACTOR,
    input wire logic [`SPA_SER_W-1:0] SER_FACTOR,
    input wire logic ALIGN_BYPASS,
    output logic CFG_ERROR,
    input wire logic [`SPA_WORD_W-1:0] TX_WORD,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic TX_SERIAL,
    output logic TX_DDR_RISE,
    output logic TX_DDR_FALL,
    output logic TX_FWD_CLK,
    output logic FABRIC_STROBE,
    input wire logic [`SPA_PHASES-1:0] RX_PHASE_BITS,
    input wire logic RX_DDR_RISE,
    input wire logic RX_DDR_FALL,
    input wire logic RX_SLIP,
    output logic [`SPA_WORD_W-1:0] RX_WORD,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic RX_ALIGN_LOCKED,
    output logic RX_OVERRUN
);

    // -------------------------------------------------------------
    // configuration check
    // -------------------------------------------------------------
    logic mult_ok;
    logic ser_ok;
    logic [`SPA_MULT_W-1:0] mult_eff;
    logic [`SPA_SER_W-1:0] ser_eff;
    logic [`SPA_SER_W-1:0] ser_last;
    logic mode_pass;
    logic mode_ddr;

    assign mult_ok = (MULT_FACTOR >= `SPA_MULT_MIN) &&
                     (MULT_FACTOR <= `SPA_MULT_MAX);
    assign ser_ok = (SER_FACTOR == `SPA_SER_PASS) ||
                    (SER_FACTOR == `SPA_SER_DDR) ||
                    ((SER_FACTOR >= `SPA_SER_MIN) &&
                     (SER_FACTOR <= `SPA_SER_MAX));
    assign mult_eff = mult_ok ? MULT_FACTOR : `SPA_MULT_DEF;
    assign ser_eff = ser_ok ? SER_FACTOR : `SPA_SER_DEF;
    assign ser_last = ser_eff - `SPA_SER_PASS;
    assign mode_pass = ser_eff == `SPA_SER_PASS;
    assign mode_ddr = ser_eff == `SPA_SER_DDR;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CFG_ERROR <= 1'b0;
        end else if (CORE_CE) begin
            CFG_ERROR <= !(mult_ok && ser_ok);
        end
    end

    // -------------------------------------------------------------
    // transmit serialiser
    // -------------------------------------------------------------
    spa_word_t tx_sh_q;
    logic [`SPA_SER_W-1:0] tx_left_q;
    logic tx_load;

    assign TX_READY = CORE_CE && (tx_left_q == '0);
    assign tx_load = TX_READY && TX_VALID;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_sh_q <= '0;
            tx_left_q <= '0;
            TX_SERIAL <= 1'b0;
        end else if (CORE_CE) begin
            if (tx_load && mode_ddr) begin
                tx_left_q <= '0;
            end else if (tx_load) begin
                TX_SERIAL <= TX_WORD[0];
                tx_sh_q <= TX_WORD >> 1;
                tx_left_q <= ser_last;
            end else if (tx_left_q != '0) begin
                TX_SERIAL <= tx_sh_q[0];
                tx_sh_q <= tx_sh_q >> 1;
                tx_left_q <= tx_left_q - `SPA_SER_PASS;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            TX_DDR_RISE <= 1'b0;
            TX_DDR_FALL <= 1'b0;
        end else if (CORE_CE && tx_load && mode_ddr) begin
            TX_DDR_RISE <= TX_WORD[0];
            TX_DDR_FALL <= TX_WORD[1];
        end
    end

    // -------------------------------------------------------------
    // forwarded fast clock and fabric strobe
    // -------------------------------------------------------------
    logic [`SPA_MULT_W-1:0] fwd_cnt_q;
    logic [`SPA_MULT_W-1:0] fwd_half;
    logic [`SPA_SER_W-1:0] fab_cnt_q;

    assign fwd_half = (mult_eff + `SPA_MULT_MIN) >> 1;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fwd_cnt_q <= '0;
            TX_FWD_CLK <= 1'b0;
        end else if (CORE_CE) begin
            if (fwd_cnt_q >= mult_eff - `SPA_MULT_MIN) begin
                fwd_cnt_q <= '0;
            end else begin
                fwd_cnt_q <= fwd_cnt_q + `SPA_MULT_MIN;
            end
            TX_FWD_CLK <= fwd_cnt_q < fwd_half;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fab_cnt_q <= '0;
            FABRIC_STROBE <= 1'b0;
        end else if (CORE_CE) begin
            if (fab_cnt_q >= ser_last) begin
                fab_cnt_q <= '0;
            end else begin
                fab_cnt_q <= fab_cnt_q + `SPA_SER_PASS;
            end
            FABRIC_STROBE <= fab_cnt_q == '0;
        end
    end

    // -------------------------------------------------------------
    // crossings into the link domain
    // -------------------------------------------------------------
    logic ce_l;
    logic byp_l;
    logic ddr_l;

    spa_sync #(.WIDTH(1)) u_ce_l (
        .clk(LINK_CLK),
        .rst_n(RSTN),
        .d(CORE_CE),
        .q(ce_l)
    );

    spa_sync #(.WIDTH(1)) u_byp_l (
        .clk(LINK_CLK),
        .rst_n(RSTN),
        .d(ALIGN_BYPASS),
        .q(byp_l)
    );

    spa_sync #(.WIDTH(1)) u_ddr_l (
        .clk(LINK_CLK),
        .rst_n(RSTN),
        .d(mode_ddr),
        .q(ddr_l)
    );

    // -------------------------------------------------------------
    // phase aligner (link domain)
    // -------------------------------------------------------------
    spa_align_t st_q;
    logic [`SPA_PHASES-1:0] ph_q;
    logic ddr_rise_q;
    logic ddr_fall_q;
    logic [`SPA_PHASES-1:0] edges;
    logic [`SPA_PHASES-1:0] acc_q;
    logic [`SPA_PHASES-1:0] acc_all;
    logic [4:0] win_q;
    logic win_end;
    logic [2:0] first_edge;
    logic [2:0] centre;
    logic [2:0] cand_q;
    logic [2:0] sel_q;
    logic locked_l;

    // phase i sees an edge when it differs from phase i-1
    assign edges = ph_q ^ {ph_q[`SPA_PHASES-2:0], ph_q[`SPA_PHASES-1]};
    assign acc_all = acc_q | edges;
    assign win_end = win_q == `SPA_WIN_LAST;

    always_comb begin
        first_edge = '0;
        for (int i = `SPA_PHASES - 1; i >= 0; i--) begin
            if (acc_all[i]) begin
                first_edge = i[2:0];
            end
        end
    end

    assign centre = first_edge + `SPA_PHASE_HALF;

    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ph_q <= '0;
            ddr_rise_q <= 1'b0;
            ddr_fall_q <= 1'b0;
        end else if (ce_l) begin
            ph_q <= RX_PHASE_BITS;
            ddr_rise_q <= RX_DDR_RISE;
            ddr_fall_q <= RX_DDR_FALL;
        end
    end

    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            win_q <= '0;
            acc_q <= '0;
        end else if (ce_l) begin
            win_q <= win_q + 5'h01;
            acc_q <= win_end ? '0 : acc_all;
        end
    end

    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= SPA_ST_SEARCH;
            cand_q <= '0;
            sel_q <= '0;
        end else if (ce_l) begin
            if (byp_l) begin
                st_q <= SPA_ST_SEARCH;
            end else begin
                unique case (st_q)
                    SPA_ST_SEARCH: begin
                        if (win_end && (acc_all != '0)) begin
                            cand_q <= centre;
                            st_q <= SPA_ST_CHECK;
                        end
                    end
                    SPA_ST_CHECK: begin
                        if (win_end && (acc_all != '0)) begin
                            cand_q <= centre;
                            if (centre == cand_q) begin
                                sel_q <= centre;
                                st_q <= SPA_ST_LOCK;
                            end
                        end
                    end
                    SPA_ST_LOCK: begin
                        st_q <= SPA_ST_LOCK;
                    end
                    default: begin
                        st_q <= SPA_ST_SEARCH;
                    end
                endcase
            end
        end
    end

    assign locked_l = (st_q == SPA_ST_LOCK) && !byp_l;

    // -------------------------------------------------------------
    // synchronizer write (link domain)
    // -------------------------------------------------------------
    logic bit_l;
    logic [`SPA_FIFO_W-1:0] wr_ent;
    logic wr_valid;
    logic wr_ready;
    logic ovr_l_q;

    assign bit_l = locked_l ? ph_q[sel_q] : ph_q[0];
    assign wr_ent = ddr_l ? {1'b1, ddr_fall_q, ddr_rise_q} :
                            {2'b00, bit_l};
    assign wr_valid = ce_l;

    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ovr_l_q <= 1'b0;
        end else if (wr_valid && !wr_ready) begin
            ovr_l_q <= 1'b1;
        end
    end

    logic rd_valid;
    logic rd_ready;
    logic [`SPA_FIFO_W-1:0] rd_ent;

    spa_fifo #(.WIDTH(`SPA_FIFO_W), .DEPTH(`SPA_FIFO_DEPTH)) u_sync_buf (
        .wr_clk(LINK_CLK),
        .wr_rst_n(RSTN),
        .wr_valid(wr_valid),
        .wr_ready(wr_ready),
        .wr_data(wr_ent),
        .rd_clk(CORE_CLK),
        .rd_rst_n(RSTN),
        .rd_valid(rd_valid),
        .rd_ready(rd_ready),
        .rd_data(rd_ent)
    );

    // -------------------------------------------------------------
    // status back into the core domain
    // -------------------------------------------------------------
    spa_sync #(.WIDTH(1)) u_lock_c (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .d(locked_l),
        .q(RX_ALIGN_LOCKED)
    );

    spa_sync #(.WIDTH(1)) u_ovr_c (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .d(ovr_l_q),
        .q(RX_OVERRUN)
    );

    // -------------------------------------------------------------
    // realigner and deserialiser (core domain)
    // -------------------------------------------------------------
    logic take;
    logic slip_q;
    logic slip_use;
    logic swap_q;
    logic fall_hold_q;
    spa_word_t des_q;
    spa_word_t des_nx;
    logic [`SPA_SER_W-1:0] cnt_q;
    logic ent_pair;
    logic word_done;
    spa_word_t word_nx;

    assign rd_ready = CORE_CE && (!RX_VALID || RX_READY);
    assign take = rd_valid && rd_ready;
    assign ent_pair = rd_ent[`SPA_ENT_PAIR];
    assign slip_use = take && slip_q;

    always_comb begin
        des_nx = des_q;
        des_nx[cnt_q] = rd_ent[`SPA_ENT_B0];
    end

    always_comb begin
        word_done = 1'b0;
        word_nx = '0;
        if (take && ent_pair) begin
            word_done = 1'b1;
            if (swap_q ^ slip_q) begin
                word_nx[1:0] = {rd_ent[`SPA_ENT_B0], fall_hold_q};
            end else begin
                word_nx[1:0] = {rd_ent[`SPA_ENT_B1], rd_ent[`SPA_ENT_B0]};
            end
        end else if (take && !slip_q && (cnt_q >= ser_last)) begin
            word_done = 1'b1;
            word_nx = des_nx;
        end
    end

    // a slip request arriving as the last one is used is kept
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            slip_q <= 1'b0;
        end else if (CORE_CE) begin
            slip_q <= (slip_q && !slip_use) || RX_SLIP;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            swap_q <= 1'b0;
            fall_hold_q <= 1'b0;
        end else if (take && ent_pair) begin
            swap_q <= swap_q ^ slip_q;
            fall_hold_q <= rd_ent[`SPA_ENT_B1];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            des_q <= '0;
            cnt_q <= '0;
        end else if (take && !ent_pair && !slip_q) begin
            if (word_done) begin
                des_q <= '0;
                cnt_q <= '0;
            end else begin
                des_q <= des_nx;
                cnt_q <= cnt_q + `SPA_SER_PASS;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RX_WORD <= '0;
            RX_VALID <= 1'b0;
        end else if (CORE_CE) begin
            if (word_done) begin
                RX_WORD <= word_nx;
                RX_VALID <= 1'b1;
            end else if (RX_READY) begin
                RX_VALID <= 1'b0;
            end
        end
    end

endmodule : spa_channel

// >>> spa_chk_sva.sv
/* port assertions for the differential channel.
   assumes it is bound onto every spa_channel. */
`timescale 1ns/1ps
`include "spa_regs.svh"

module spa_chk (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CORE_CE,
    input wire logic [`SPA_MULT_W-1:0] MULT_FACTOR,
    input wire logic [`SPA_SER_W-1:0] SER_FACTOR,
    input wire logic ALIGN_BYPASS,
    input wire logic CFG_ERROR,
    input wire logic [`SPA_WORD_W-1:0] TX_WORD,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_SERIAL,
    input wire logic TX_DDR_RISE,
    input wire logic TX_DDR_FALL,
    input wire logic TX_FWD_CLK,
    input wire logic FABRIC_STROBE,
    input wire logic [`SPA_WORD_W-1:0] RX_WORD,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic RX_ALIGN_LOCKED,
    input wire logic RX_OVERRUN
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    sequence s_take;
        TX_VALID && TX_READY && !CFG_ERROR;
    endsequence
    sequence s_gap3;
        !FABRIC_STROBE [*3];
    endsequence
    property p_cfg_err;
        SER_FACTOR == 4'h3 || MULT_FACTOR == 6'h00 |=> CFG_ERROR;
    endproperty
    a_cfg_err: assert property (p_cfg_err) else $error("cfg flag missed");
    property p_tx_busy;
        s_take ##0 SER_FACTOR == 4'h4 |=> !TX_READY [*3] ##1 TX_READY;
    endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("tx busy span");
    property p_tx_bits;
        s_take ##0 SER_FACTOR >= 4'h4 && SER_FACTOR <= 4'ha |->
            ##1 TX_SERIAL == $past(TX_WORD[0])
            ##1 TX_SERIAL == $past(TX_WORD[1], 2);
    endproperty
    a_tx_bits: assert property (p_tx_bits) else $error("tx bit order");
    property p_pass;
        s_take ##0 SER_FACTOR == 4'h1 |=> TX_SERIAL == $past(TX_WORD[0]);
    endproperty
    a_pass: assert property (p_pass) else $error("tx pass bit");
    property p_ddr;
        s_take ##0 SER_FACTOR == 4'h2 |=> TX_DDR_RISE == $past(TX_WORD[0])
            && TX_DDR_FALL == $past(TX_WORD[1]);
    endproperty
    a_ddr: assert property (p_ddr) else $error("tx ddr pair");
    property p_strobe;
        disable iff (!RSTN || !CORE_CE || SER_FACTOR != 4'h4)
        FABRIC_STROBE |=> s_gap3 ##1 FABRIC_STROBE;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe period");
    property p_fwd;
        disable iff (!RSTN || !CORE_CE || MULT_FACTOR != 6'h04)
        $rose(TX_FWD_CLK) |-> TX_FWD_CLK [*2] ##1 !TX_FWD_CLK [*2]
            ##1 TX_FWD_CLK;
    endproperty
    a_fwd: assert property (p_fwd) else $error("fwd clock shape");
    property p_rx_hold;
        RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
    property p_bypass;
        ALIGN_BYPASS [*8] |-> !RX_ALIGN_LOCKED;
    endproperty
    a_bypass: assert property (p_bypass) else $error("lock in bypass");
    property p_overrun;
        RX_OVERRUN |=> RX_OVERRUN;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun cleared");
endmodule : spa_chk

bind spa_channel spa_chk u_chk (.*);

// >>> spa_link_src.sv
/* far-side source: one bit per link clock rising edge on eight phase taps.
   assumes the bench supplies the link clock. */
`timescale 1ns/1ps

module spa_link_src (
    input wire logic link_clk,
    input wire logic en,
    input wire logic toggle,
    input wire logic [2:0] skew,
    output logic [7:0] phase_bits,
    output logic ddr_rise,
    output logic ddr_fall
);
    logic bit_q = 1'b0;
    logic prev_q = 1'b0;

    always_ff @(posedge link_clk) begin
        prev_q <= bit_q;
        bit_q <= (en && !toggle) ? 1'b1 : ~bit_q;
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            phase_bits[k] = (k < skew) ? prev_q : bit_q;
        end
    end
    assign ddr_rise = en ? 1'b1 : bit_q;
    assign ddr_fall = en ? 1'b0 : ~bit_q;
endmodule : spa_link_src

// >>> spa_channel_tb.sv
/* self-checking bench for spa_channel with link source model.
   assumes spa_chk is bound from its own file. */
`timescale 1ns/1ps
`include "spa_regs.svh"

module spa_channel_tb
    import spa_pkg::*;
;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n, ce, byp, tx_valid, rx_slip, rx_ready, toggle, e;
    logic [5:0] mult;
    logic [3:0] ser;
    spa_word_t tx_word, rx_word, w;
    logic cfg_err, tx_ready, tx_ser, ddr_r, ddr_f, fwd, strobe;
    logic rx_valid, locked, overrun, pr, pf;
    logic [7:0] ph;
    logic [10:0] cfg_tab [8];
    int err_count = 0;
    int num_checks = 0;
    int i;

    always #12.5 clk = ~clk;
    initial #1.3 forever #3 lclk = ~lclk;

    spa_channel u_dut (
        .CORE_CLK(clk),
        .RSTN(rst_n),
        .CORE_CE(ce),
        .LINK_CLK(lclk),
        .MULT_FACTOR(mult),
        .SER_FACTOR(ser),
        .ALIGN_BYPASS(byp),
        .CFG_ERROR(cfg_err),
        .TX_WORD(tx_word),
        .TX_VALID(tx_valid),
        .TX_READY(tx_ready),
        .TX_SERIAL(tx_ser),
        .TX_DDR_RISE(ddr_r),
        .TX_DDR_FALL(ddr_f),
        .TX_FWD_CLK(fwd),
        .FABRIC_STROBE(strobe),
        .RX_PHASE_BITS(ph),
        .RX_DDR_RISE(pr),
        .RX_DDR_FALL(pf),
        .RX_SLIP(rx_slip),
        .RX_WORD(rx_word),
        .RX_VALID(rx_valid),
        .RX_READY(rx_ready),
        .RX_ALIGN_LOCKED(locked),
        .RX_OVERRUN(overrun)
    );
    spa_link_src u_src (
        .link_clk(lclk),
        .en(1'b1),
        .toggle(toggle),
        .skew(3'h3),
        .phase_bits(ph),
        .ddr_rise(pr),
        .ddr_fall(pf)
    );

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input string nm, input spa_word_t s, spa_word_t x);
        num_checks++;
        if (s !== x) begin
            err_count++;
            $display("FAIL %s exp %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic send(input spa_word_t v, input logic [3:0] j);
        int k;
        ser = j;
        tx_word = v;
        tx_valid = 1'b1;
        for (k = 0; k < 50 && tx_ready !== 1'b1; k++) step(1);
        step(1);
        tx_valid = 1'b0;
        if (j == 4'h2) begin
            check("ddr", spa_word_t'({ddr_f, ddr_r}), v & 10'h003);
        end else begin
            for (k = 0; k < j; k++) begin
                check("tx bit", spa_word_t'(tx_ser), spa_word_t'(v[k]));
                if (k + 1 < j) step(1);
            end
        end
        if (j < 4'h4) step(1);
    endtask : send
    task automatic get_rx();
        int k;
        for (k = 0; k < 100 && rx_valid !== 1'b1; k++) step(1);
        w = rx_word;
        step(1);
    endtask : get_rx
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // -------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        byp = 1'b1;
        mult = 6'h04;
        ser = 4'h4;
        tx_word = 10'h000;
        tx_valid = 1'b0;
        rx_slip = 1'b0;
        rx_ready = 1'b1;
        toggle = 1'b0;
        w = 10'h000;
        cfg_tab = '{{6'h01, 4'h4, 1'b0}, {6'h20, 4'ha, 1'b0},
            {6'h00, 4'h4, 1'b1}, {6'h21, 4'h4, 1'b1}, {6'h04, 4'h3, 1'b1},
            {6'h04, 4'hb, 1'b1}, {6'h04, 4'h1, 1'b0}, {6'h04, 4'h2, 1'b0}};
        repeat (4) @(posedge clk);
        #2 rst_n = 1'b1;
        step(8);
        for (i = 0; i < 8; i++) begin
            {mult, ser, e} = cfg_tab[i];
            step(3);
            check("cfg err", spa_word_t'(cfg_err), spa_word_t'(e));
        end
        mult = 6'h04;
        for (int j = 1; j <= 10; j++) begin
            if (j != 3) begin
                send(10'h2b5, j[3:0]);
                send(10'h14a, j[3:0]);
            end
        end
        ce = 1'b0;
        step(6);
        ce = 1'b1;
        ser = 4'h4;
        step(12);
        repeat (4) get_rx();
        check("rx j4", w, 10'h00f);
        ser = 4'h1;
        repeat (4) get_rx();
        check("rx j1", w, 10'h001);
        ser = 4'ha;
        repeat (4) get_rx();
        check("rx j10", w, 10'h3ff);
        ser = 4'h2;
        repeat (12) get_rx();
        check("rx ddr", w, 10'h001);
        for (i = 0; i < 8 && w !== 10'h002; i++) begin
            rx_slip = 1'b1;
            step(1);
            rx_slip = 1'b0;
            repeat (4) get_rx();
        end
        check("rx slip", w, 10'h002);
        rx_ready = 1'b0;
        step(40);
        check("overrun", spa_word_t'(overrun), 10'h001);
        rx_ready = 1'b1;
        ser = 4'h4;
        toggle = 1'b1;
        byp = 1'b0;
        for (i = 0; i < 300 && locked !== 1'b1; i++) step(1);
        check("lock", spa_word_t'(locked), 10'h001);
        byp = 1'b1;
        step(12);
        check("bypass", spa_word_t'(locked), 10'h000);
        rst_n = 1'b0;
        step(4);
        check("rst overrun", spa_word_t'(overrun), 10'h000);
        rst_n = 1'b1;
        step(4);
        summarize();
    end

    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule : spa_channel_tb
